// [verilog/lpfs_cfg.svh]
// Purpose: Constants for the LCD shared pin function select block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Included by its bare name; definitions only
`ifndef LPFS_CFG_SVH
`define LPFS_CFG_SVH

// Register word indices
`define LPFS_IDX_SEG_SELECT_0      22'h0F0300
`define LPFS_IDX_SEG_SELECT_1      22'h0F0301
`define LPFS_IDX_SEG_SELECT_2      22'h0F0302
`define LPFS_IDX_SEG_SELECT_3      22'h0F0303
`define LPFS_IDX_SEG_SELECT_4      22'h0F0304
`define LPFS_IDX_SEG_SELECT_5      22'h0F0305
`define LPFS_IDX_INPUT_SWITCH      22'h0F0308
`define LPFS_IDX_MODE_A            22'h0F0310
`define LPFS_IDX_MODE_B            22'h0F0311
`define LPFS_IDX_PORT_DIR_0        22'h0FFF20
`define LPFS_IDX_PORT_DIR_1        22'h0FFF21
`define LPFS_IDX_PORT_DIR_3        22'h0FFF23
`define LPFS_IDX_PORT_DIR_5        22'h0FFF25
`define LPFS_IDX_PORT_DIR_7        22'h0FFF27
`define LPFS_IDX_PORT_DIR_8        22'h0FFF28
`define LPFS_IDX_PORT_DIR_12       22'h0FFF2C

// Reset values
`define LPFS_RST_SEG_SELECT        8'hFF
`define LPFS_RST_SEG_SELECT_0      8'hF0
`define LPFS_RST_SEG_SELECT_5      8'h1F
`define LPFS_RST_PORT_DIR          8'hFF
`define LPFS_RST_INPUT_SWITCH      8'h00
`define LPFS_RST_MODE              8'h00

// Field positions
`define LPFS_BIT_CAP_INPUT_EN      0
`define LPFS_BIT_BIAS_INPUT_EN     1
`define LPFS_BIT_SEG_START         6
`define LPFS_POS_BIAS_LO           3
`define LPFS_POS_DRIVE_LO          6
`define LPFS_BIT_BIAS_DIR          5
`define LPFS_BIT_BOOST_CAP_LOW_DIR          6
`define LPFS_BIT_BOOST_CAP_HIGH_DIR          7

// Field encodings
`define LPFS_BIAS_QUARTER          2'h2
`define LPFS_DRIVE_RESISTOR        2'h0
`define LPFS_DRIVE_BOOST           2'h1
`define LPFS_DRIVE_SPLIT           2'h2

// Segment index range of shared pins
`define LPFS_SEG_FIRST             4
`define LPFS_SEG_LAST              44

`endif

// [verilog/lpfs_pkg.sv]
// Purpose: Types for the LCD shared pin function select block
// Assumes: Constants live in lpfs_cfg.svh
// Notes:   No imports; users write lpfs_pkg::name
package lpfs_pkg;

  // Function a shared pin can take
  typedef enum logic [2:0] {
    PIN_INPUT_OFF,
    PIN_DIG_OUT,
    PIN_DIG_IN,
    PIN_SEG_OUT,
    PIN_LCD_FUNC
  } lpfs_pin_mode_e;

endpackage

// [verilog/lpfs_top.sv]
// Purpose: Pin function select for pins shared between ports and the LCD driver
// Assumes: Classic Wishbone slave, 8-bit registers in the low byte of each word
// Notes:   Bias and boost cap pins plus segment pins 4 to 44
`timescale 1ns/1ps
`include "lpfs_cfg.svh"
`default_nettype none

module lpfs_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [23:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [44:4] seg_pad_in_i,
  output logic      [44:4] seg_pad_out_o,
  output logic      [44:4] seg_pad_oe_n_o,
  input  wire logic [44:4] port_latch_i,
  input  wire logic [44:4] seg_wave_i,
  output logic      [44:4] port_pin_o,
  input  wire logic [2:0]  lcd_pad_in_i,
  output logic      [2:0]  lcd_pad_out_o,
  output logic      [2:0]  lcd_pad_oe_n_o,
  input  wire logic [2:0]  lcd_latch_i,
  output logic      [2:0]  lcd_port_pin_o,
  output logic      [2:0]  lcd_func_o,
  output logic      [1:0]  schmitt_en_o,
  output logic      [1:0]  bias_select_o,
  output logic      [1:0]  drive_method_o,
  output logic             segment_output_start_o
);

  // Register state
  logic [44:4] seg_sel_reg;
  logic [7:0]  pdir0_reg;
  logic [7:1]  pdir1_reg;
  logic [7:0]  pdir3_reg;
  logic [7:0]  pdir5_reg;
  logic [7:0]  pdir7_reg;
  logic [1:0]  pdir8_reg;
  logic [7:5]  pdir12_reg;
  logic [1:0]  in_sw_reg;
  logic [7:0]  mode_a_reg;
  logic        seg_start_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [7:0]  rdat_next;
  logic        wr_stb;
  logic [21:0] idx;
  logic        aligned;
  logic [44:4] seg_dir;
  logic [44:4] seg_sync1_reg;
  logic [44:4] seg_sync2_reg;
  logic [2:0]  lcd_sync1_reg;
  logic [2:0]  lcd_sync2_reg;
  logic [1:0]  bias_sel;
  logic [1:0]  drive_sel;

  assign idx       = wb_adr_i[23:2];
  assign aligned   = (wb_adr_i[1:0] == 2'h0);
  // Write lands on the edge at which the master sees ack; a dropped cycle writes nothing
  assign wr_stb    = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0] & aligned;
  assign bias_sel  = mode_a_reg[`LPFS_POS_BIAS_LO +: 2];
  assign drive_sel = mode_a_reg[`LPFS_POS_DRIVE_LO +: 2];

  // Bus handshake, one wait state; unmapped words still ack, read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  // Segment select bits, unimplemented bits never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_sel_reg[7:4]   <= 4'(`LPFS_RST_SEG_SELECT_0 >> 4);
      seg_sel_reg[15:8]  <= `LPFS_RST_SEG_SELECT;
      seg_sel_reg[23:16] <= `LPFS_RST_SEG_SELECT;
      seg_sel_reg[31:24] <= `LPFS_RST_SEG_SELECT;
      seg_sel_reg[39:32] <= `LPFS_RST_SEG_SELECT;
      seg_sel_reg[44:40] <= 5'(`LPFS_RST_SEG_SELECT_5);
    end else if (wr_stb) begin
      case (idx)
        `LPFS_IDX_SEG_SELECT_0: seg_sel_reg[7:4]   <= wb_dat_i[7:4];
        `LPFS_IDX_SEG_SELECT_1: seg_sel_reg[15:8]  <= wb_dat_i[7:0];
        `LPFS_IDX_SEG_SELECT_2: seg_sel_reg[23:16] <= wb_dat_i[7:0];
        `LPFS_IDX_SEG_SELECT_3: seg_sel_reg[31:24] <= wb_dat_i[7:0];
        `LPFS_IDX_SEG_SELECT_4: seg_sel_reg[39:32] <= wb_dat_i[7:0];
        `LPFS_IDX_SEG_SELECT_5: seg_sel_reg[44:40] <= wb_dat_i[4:0];
        default: ;
      endcase
    end
  end

  // Port direction registers; fixed-one bits are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pdir0_reg  <= `LPFS_RST_PORT_DIR;
      pdir1_reg  <= 7'(`LPFS_RST_PORT_DIR >> 1);
      pdir3_reg  <= `LPFS_RST_PORT_DIR;
      pdir5_reg  <= `LPFS_RST_PORT_DIR;
      pdir7_reg  <= `LPFS_RST_PORT_DIR;
      pdir8_reg  <= 2'(`LPFS_RST_PORT_DIR >> 6);
      pdir12_reg <= 3'(`LPFS_RST_PORT_DIR >> 5);
    end else if (wr_stb) begin
      case (idx)
        `LPFS_IDX_PORT_DIR_0:  pdir0_reg  <= wb_dat_i[7:0];
        `LPFS_IDX_PORT_DIR_1:  pdir1_reg  <= wb_dat_i[7:1];
        `LPFS_IDX_PORT_DIR_3:  pdir3_reg  <= wb_dat_i[7:0];
        `LPFS_IDX_PORT_DIR_5:  pdir5_reg  <= wb_dat_i[7:0];
        `LPFS_IDX_PORT_DIR_7:  pdir7_reg  <= wb_dat_i[7:0];
        `LPFS_IDX_PORT_DIR_8:  pdir8_reg  <= wb_dat_i[1:0];
        `LPFS_IDX_PORT_DIR_12: pdir12_reg <= wb_dat_i[7:5];
        default: ;
      endcase
    end
  end

  // LCD input switch and mode registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_sw_reg     <= 2'(`LPFS_RST_INPUT_SWITCH);
      mode_a_reg    <= `LPFS_RST_MODE;
      seg_start_reg <= 1'b0;
    end else if (wr_stb) begin
      case (idx)
        `LPFS_IDX_INPUT_SWITCH: in_sw_reg     <= wb_dat_i[1:0];
        `LPFS_IDX_MODE_A:       mode_a_reg    <= wb_dat_i[7:0];
        `LPFS_IDX_MODE_B:       seg_start_reg <= wb_dat_i[`LPFS_BIT_SEG_START];
        default: ;
      endcase
    end
  end

  // Read mux; bits with no storage read as zero or as their fixed one
  always_comb begin
    rdat_next = 8'h00;
    case (idx)
      `LPFS_IDX_SEG_SELECT_0: rdat_next = {seg_sel_reg[7:4], 4'h0};
      `LPFS_IDX_SEG_SELECT_1: rdat_next = seg_sel_reg[15:8];
      `LPFS_IDX_SEG_SELECT_2: rdat_next = seg_sel_reg[23:16];
      `LPFS_IDX_SEG_SELECT_3: rdat_next = seg_sel_reg[31:24];
      `LPFS_IDX_SEG_SELECT_4: rdat_next = seg_sel_reg[39:32];
      `LPFS_IDX_SEG_SELECT_5: rdat_next = {3'h0, seg_sel_reg[44:40]};
      `LPFS_IDX_INPUT_SWITCH: rdat_next = {6'h00, in_sw_reg};
      `LPFS_IDX_MODE_A:       rdat_next = mode_a_reg;
      `LPFS_IDX_MODE_B:       rdat_next = {1'b0, seg_start_reg, 6'h00};
      `LPFS_IDX_PORT_DIR_0:   rdat_next = pdir0_reg;
      `LPFS_IDX_PORT_DIR_1:   rdat_next = {pdir1_reg, 1'b1};
      `LPFS_IDX_PORT_DIR_3:   rdat_next = pdir3_reg;
      `LPFS_IDX_PORT_DIR_5:   rdat_next = pdir5_reg;
      `LPFS_IDX_PORT_DIR_7:   rdat_next = pdir7_reg;
      `LPFS_IDX_PORT_DIR_8:   rdat_next = {6'h3F, pdir8_reg};
      `LPFS_IDX_PORT_DIR_12:  rdat_next = {pdir12_reg, 5'h1F};
      default:                rdat_next = 8'h00;
    endcase
    if (!aligned) begin
      rdat_next = 8'h00;
    end
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      rdat_reg <= {24'h000000, rdat_next};
    end
  end

  // Direction bit that belongs to each segment pin, by its alternate port
  assign seg_dir[11:4]  = pdir5_reg;
  assign seg_dir[19:12] = pdir7_reg;
  assign seg_dir[27:20] = pdir3_reg;
  assign seg_dir[32:28] = pdir1_reg[7:3];
  assign seg_dir[40:33] = pdir0_reg;
  assign seg_dir[41]    = pdir1_reg[2];
  assign seg_dir[42]    = pdir1_reg[1];
  assign seg_dir[43]    = pdir8_reg[1];
  assign seg_dir[44]    = pdir8_reg[0];

  // Pad input synchronisers; pins are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_sync1_reg <= '0;
      seg_sync2_reg <= '0;
      lcd_sync1_reg <= 3'h0;
      lcd_sync2_reg <= 3'h0;
    end else begin
      seg_sync1_reg <= seg_pad_in_i;
      seg_sync2_reg <= seg_sync1_reg;
      lcd_sync1_reg <= lcd_pad_in_i;
      lcd_sync2_reg <= lcd_sync1_reg;
    end
  end

  // Per segment pin decode and registered pad drive
  genvar g;
  generate
    for (g = `LPFS_SEG_FIRST; g <= `LPFS_SEG_LAST; g = g + 1) begin : g_seg
      lpfs_pkg::lpfs_pin_mode_e mode;
      always_comb begin
        case ({seg_sel_reg[g], seg_dir[g]})
          2'h3:    mode = lpfs_pkg::PIN_INPUT_OFF;
          2'h0:    mode = lpfs_pkg::PIN_DIG_OUT;
          2'h1:    mode = lpfs_pkg::PIN_DIG_IN;
          2'h2:    mode = lpfs_pkg::PIN_SEG_OUT;
          default: mode = lpfs_pkg::PIN_INPUT_OFF;
        endcase
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          seg_pad_out_o[g]  <= 1'b0;
          seg_pad_oe_n_o[g] <= 1'b1;
          port_pin_o[g]     <= 1'b0;
        end else begin
          case (mode)
            lpfs_pkg::PIN_DIG_OUT: begin
              seg_pad_out_o[g]  <= port_latch_i[g];
              seg_pad_oe_n_o[g] <= 1'b0;
              port_pin_o[g]     <= seg_sync2_reg[g];
            end
            lpfs_pkg::PIN_DIG_IN: begin
              seg_pad_out_o[g]  <= 1'b0;
              seg_pad_oe_n_o[g] <= 1'b1;
              port_pin_o[g]     <= seg_sync2_reg[g];
            end
            lpfs_pkg::PIN_SEG_OUT: begin
              // Waveform only once segment output runs; low until then
              seg_pad_out_o[g]  <= seg_wave_i[g] & seg_start_reg;
              seg_pad_oe_n_o[g] <= 1'b0;
              port_pin_o[g]     <= 1'b0;
            end
            default: begin
              seg_pad_out_o[g]  <= 1'b0;
              seg_pad_oe_n_o[g] <= 1'b1;
              port_pin_o[g]     <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // Bias pin and the two boost cap pins: index 0 bias, 1 cap low, 2 cap high
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_lcd
      lpfs_pkg::lpfs_pin_mode_e mode;
      logic sw;
      logic dir;
      logic func_ok;
      logic func_sel;
      always_comb begin
        if (g == 0) begin
          sw       = in_sw_reg[`LPFS_BIT_BIAS_INPUT_EN];
          dir      = pdir12_reg[`LPFS_BIT_BIAS_DIR];
          func_sel = (bias_sel == `LPFS_BIAS_QUARTER);
          func_ok  = dir;
        end else begin
          sw       = in_sw_reg[`LPFS_BIT_CAP_INPUT_EN];
          dir      = pdir12_reg[`LPFS_BIT_BIAS_DIR + g];
          func_sel = (drive_sel == `LPFS_DRIVE_BOOST) || (drive_sel == `LPFS_DRIVE_SPLIT);
          // Both cap directions must be input before either pin connects
          func_ok  = pdir12_reg[`LPFS_BIT_BOOST_CAP_LOW_DIR] & pdir12_reg[`LPFS_BIT_BOOST_CAP_HIGH_DIR];
        end
        mode = lpfs_pkg::PIN_INPUT_OFF;
        if (func_sel) begin
          // Prohibited combinations fall back to a safe input-off pin
          if (!sw && func_ok) begin
            mode = lpfs_pkg::PIN_LCD_FUNC;
          end
        end else if ((g == 0) || (drive_sel == `LPFS_DRIVE_RESISTOR)) begin
          case ({sw, dir})
            2'h1:    mode = lpfs_pkg::PIN_INPUT_OFF;
            2'h2:    mode = lpfs_pkg::PIN_DIG_OUT;
            2'h3:    mode = lpfs_pkg::PIN_DIG_IN;
            default: mode = lpfs_pkg::PIN_INPUT_OFF;
          endcase
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lcd_pad_out_o[g]  <= 1'b0;
          lcd_pad_oe_n_o[g] <= 1'b1;
          lcd_port_pin_o[g] <= 1'b0;
          lcd_func_o[g]     <= 1'b0;
        end else begin
          lcd_pad_out_o[g]  <= (mode == lpfs_pkg::PIN_DIG_OUT) & lcd_latch_i[g];
          lcd_pad_oe_n_o[g] <= (mode != lpfs_pkg::PIN_DIG_OUT);
          // Input reaches the port only with the Schmitt buffer on
          lcd_port_pin_o[g] <= sw & lcd_sync2_reg[g] & (mode != lpfs_pkg::PIN_LCD_FUNC);
          lcd_func_o[g]     <= (mode == lpfs_pkg::PIN_LCD_FUNC);
        end
      end
    end
  endgenerate

  // Control outputs toward the pads and the LCD driver
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      schmitt_en_o           <= 2'h0;
      bias_select_o          <= 2'h0;
      drive_method_o         <= 2'h0;
      segment_output_start_o <= 1'b0;
    end else begin
      schmitt_en_o           <= in_sw_reg;
      bias_select_o          <= bias_sel;
      drive_method_o         <= drive_sel;
      segment_output_start_o <= seg_start_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

endmodule

`default_nettype wire

// [dv/lpfs_pad_model.sv]
// Purpose: Far-side pads of the LCD glass and external bias parts
// Assumes: Outside source drives only where the block lets a pin go
// Notes:   One model serves the segment pins and the three analog pins
`timescale 1ns/1ps
`default_nettype none
module lpfs_pad_model #(
  parameter int W = 44
) (
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] pad_o
);
  // Wire level: block drive wins, else the outside source
  assign pad_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule
`default_nettype wire

// [dv/lpfs_top_asserts.sv]
// Purpose: Port checks for the LCD shared pin select block
// Assumes: Outputs are registers one edge behind the configuration
// Notes:   Stable guards keep lag between copies from raising alarms
`timescale 1ns/1ps
`default_nettype none
module lpfs_top_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [44:4] seg_pad_oe_n_o,
  input wire logic [2:0]  lcd_pad_in_i,
  input wire logic [2:0]  lcd_pad_oe_n_o,
  input wire logic [2:0]  lcd_port_pin_o,
  input wire logic [2:0]  lcd_func_o,
  input wire logic [1:0]  schmitt_en_o,
  input wire logic [1:0]  bias_select_o,
  input wire logic [1:0]  drive_method_o,
  input wire logic        segment_output_start_o
);
  // One clock domain for every check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers one cycle after the request, for one cycle only
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer missing");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer too long");
  dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // Every pin leaves reset released and unconnected
  reset_pins_a: assert property ($fell(rst_i) |-> &seg_pad_oe_n_o && &lcd_pad_oe_n_o
    && lcd_func_o == 3'h0 && schmitt_en_o == 2'h0 && !segment_output_start_o)
    else $error("pins not released after reset");
  // Pad level reaches port side three edges on, gated by the buffer switch
  pin_follow_a: assert property ($stable(schmitt_en_o) |-> lcd_port_pin_o ==
    ({schmitt_en_o[0], schmitt_en_o[0], schmitt_en_o[1]} & $past(lcd_pad_in_i, 3)))
    else $error("analog pin input buffer wrong");
  // Analog functions only in their one legal combination
  bias_func_a: assert property (lcd_func_o[0] && $stable(bias_select_o)
    && $stable(schmitt_en_o) |-> bias_select_o == 2'h2 && !schmitt_en_o[1])
    else $error("bias level function wrongly connected");
  cap_func_a: assert property (lcd_func_o[1] && $stable(drive_method_o)
    && $stable(schmitt_en_o) |-> lcd_func_o[2] && !schmitt_en_o[0]
    && drive_method_o inside {2'h1, 2'h2})
    else $error("boost cap function wrongly connected");
  // Port drive on analog pins needs the buffer on and port mode
  bias_drv_a: assert property (!lcd_pad_oe_n_o[0] && $stable(bias_select_o)
    && $stable(schmitt_en_o) |-> schmitt_en_o[1] && bias_select_o != 2'h2)
    else $error("bias pin driven in wrong mode");
  cap_drv_a: assert property (lcd_pad_oe_n_o[2:1] != 2'h3 && $stable(drive_method_o)
    && $stable(schmitt_en_o) |-> schmitt_en_o[0] && drive_method_o == 2'h0)
    else $error("cap pin driven in wrong mode");
endmodule

bind lpfs_top lpfs_top_chk lpfs_top_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .seg_pad_oe_n_o, .lcd_pad_in_i, .lcd_pad_oe_n_o,
  .lcd_port_pin_o, .lcd_func_o, .schmitt_en_o, .bias_select_o, .drive_method_o,
  .segment_output_start_o);
`default_nettype wire

// [dv/lpfs_top_tb.sv]
// Purpose: Self-checking bench for the LCD shared pin select block
// Assumes: Wishbone answer comes one cycle after each request
// Notes:   Pins are seen through the pad model at the far side
`timescale 1ns/1ps
`default_nettype none
`include "lpfs_cfg.svh"
module lpfs_top_tb;
  localparam logic [21:0] SEG0 = `LPFS_IDX_SEG_SELECT_0;
  localparam logic [21:0] DIR0 = `LPFS_IDX_PORT_DIR_0;
  localparam logic [21:0] MB   = `LPFS_IDX_MODE_B;
  localparam int          PP [8] = '{4, 19, 20, 28, 40, 41, 42, 44};
  localparam int          DR [8] = '{5, 7, 3, 1, 0, 1, 1, 8};
  localparam int          DB [8] = '{0, 7, 0, 3, 7, 2, 1, 0};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, start;
  logic [3:0]  sel = 4'h0;
  logic [23:0] adr = 24'h000000;
  logic [31:0] wdat = 32'h00000000, rdat;
  logic [44:4] seg_out, seg_oe_n, port_pin;
  logic [44:4] latch = 41'h0, wave = 41'h0, seg_ext = 41'h0;
  logic [2:0]  lcd_out, lcd_oe_n, lcd_pin, func;
  logic [2:0]  lcd_latch = 3'h0;
  logic [1:0]  sch, bias, drive;
  wire  logic [43:0] pad;
  int          bad_count = 0;
  int          checks_done = 0;

  // Free-running 125 MHz clock
  always #4 clk_i = ~clk_i;

  // Block under test and its far-side pads
  lpfs_top lpfs_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .seg_pad_in_i(pad[43:3]), .seg_pad_out_o(seg_out), .seg_pad_oe_n_o(seg_oe_n),
    .port_latch_i(latch), .seg_wave_i(wave), .port_pin_o(port_pin),
    .lcd_pad_in_i(pad[2:0]), .lcd_pad_out_o(lcd_out), .lcd_pad_oe_n_o(lcd_oe_n),
    .lcd_latch_i(lcd_latch), .lcd_port_pin_o(lcd_pin), .lcd_func_o(func),
    .schmitt_en_o(sch), .bias_select_o(bias), .drive_method_o(drive),
    .segment_output_start_o(start)
  );
  lpfs_pad_model #(.W(44)) lpfs_pad_model_i (
    .oe_n_i({seg_oe_n, lcd_oe_n}), .out_i({seg_out, lcd_out}),
    .ext_i({seg_ext, 3'h7}), .pad_o(pad)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; waits for the answer, then checks it came on the second edge
  task automatic wb(input logic [21:0] idx, input logic w, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'hF;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h000000, d};
    n = 0;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    check("bus answer", n, 32'h2);
  endtask

  task automatic wr(input logic [21:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(idx, 1'b1, d, q);
  endtask

  task automatic rd(input logic [21:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(idx, 1'b0, 8'h00, q);
    check($sformatf("reg %h", idx), q, {24'h000000, e});
  endtask

  // Walks one segment pin through all select/direction pairs, output not started
  task automatic pin(input int p, input logic [21:0] di, input int db);
    logic [21:0] si;
    logic        s, d, v;
    si = 22'(SEG0 + p / 8);
    for (int c = 0; c < 8; c++) begin
      s = c[2];
      d = c[1];
      v = c[0];
      latch[p] <= v & !s;
      wave[p] <= v;
      seg_ext[p] <= v;
      wr(si, s ? 8'hFF : ~(8'h01 << (p % 8)));
      wr(di, d ? 8'hFF : ~(8'h01 << db));
      repeat (5) @(posedge clk_i);
      check("pad enable", seg_oe_n[p], d);
      if (!d) check("pad value", seg_out[p], !s & v);
      if (s | d) check("port pin", port_pin[p], !s & v);
    end
  endtask

  // Analog pin case: mode fields, switches, directions, expected enables
  task automatic lcd(input logic [7:0] ma, input logic [1:0] sw, input logic [7:0] dir,
                     input logic [2:0] oe, input logic [2:0] f);
    logic [2:0] l;
    l = {sw[0], sw[0], sw[1]};
    lcd_latch <= l;
    wr(`LPFS_IDX_MODE_A, ma);
    wr(`LPFS_IDX_INPUT_SWITCH, {6'h00, sw});
    wr(`LPFS_IDX_PORT_DIR_12, dir);
    repeat (5) @(posedge clk_i);
    check("lcd func", func, f);
    check("lcd enable", lcd_oe_n, oe);
    check("lcd out", lcd_out & ~lcd_oe_n, ~oe & l);
    check("lcd pin", lcd_pin, l);
    check("buffer", sch, sw);
    check("fields", {bias, drive}, {ma[4:3], ma[7:6]});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog far past the expected run of under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end

  // Main sequence: reset values, masks, segment pins, analog pins, start
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(22'(SEG0 + i), i == 0 ? 8'hF0 : i == 5 ? 8'h1F : 8'hFF);
    for (int i = 0; i < 8; i++) rd(22'(DIR0 + DR[i]), 8'hFF);
    rd(`LPFS_IDX_INPUT_SWITCH, 8'h00);
    rd(`LPFS_IDX_MODE_A, 8'h00);
    rd(MB, 8'h00);
    wr(SEG0, 8'h0F);
    rd(SEG0, 8'h00);
    wr(22'(SEG0 + 5), 8'hE0);
    rd(22'(SEG0 + 5), 8'h00);
    wr(22'(DIR0 + 1), 8'h00);
    rd(22'(DIR0 + 1), 8'h01);
    wr(22'(DIR0 + 8), 8'h00);
    rd(22'(DIR0 + 8), 8'hFC);
    wr(22'h000001, 8'h55);
    rd(22'h000001, 8'h00);
    for (int i = 0; i < 8; i++) pin(PP[i], 22'(DIR0 + DR[i]), DB[i]);
    lcd(8'h00, 2'h0, 8'hFF, 3'h7, 3'h0);
    lcd(8'h08, 2'h3, 8'h1F, 3'h0, 3'h0);
    lcd(8'h00, 2'h3, 8'hFF, 3'h7, 3'h0);
    lcd(8'h50, 2'h0, 8'hFF, 3'h7, 3'h7);
    lcd(8'h90, 2'h0, 8'hFF, 3'h7, 3'h7);
    lcd(8'h50, 2'h2, 8'hBF, 3'h7, 3'h0);
    lcd(8'hC0, 2'h0, 8'hFF, 3'h7, 3'h0);
    lcd(8'h50, 2'h0, 8'hFF, 3'h7, 3'h7);
    latch[4] <= 1'b0;
    wr(SEG0, 8'hFF);
    wr(22'(DIR0 + 5), 8'hFE);
    wr(MB, 8'h40);
    for (int v = 0; v < 2; v++) begin
      wave[4] <= v[0];
      repeat (5) @(posedge clk_i);
      check("segment wave", seg_out[4], v[0]);
    end
    check("start", start, 1'b1);
    wr(MB, 8'hFF);
    rd(MB, 8'h40);
    wrap_up();
  end
endmodule
`default_nettype wire
